// ---- logic/tls_pkg.sv ----
// package: register map, field positions, commands and widths of the level sequencer
package tls_pkg;
  // ------------------------------------------------------------------
  // widths and limits
  // ------------------------------------------------------------------
  localparam int          LVL_W          = 16;
  localparam logic [15:0] CURR_MIN       = 16'h0000;
  localparam logic [15:0] CURR_MAX       = 16'hFFF0;
  localparam logic [15:0] TRIG_MIN       = 16'h0000;
  localparam logic [15:0] TRIG_MAX       = 16'hFFF0;
  localparam logic [15:0] CURR_RST       = 16'h0000;
  localparam logic [15:0] VOLT_RST       = 16'h0000;

  // ------------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] A_CMD       = 8'h00;
  localparam logic [7:0] A_CURR_IMM  = 8'h04;
  localparam logic [7:0] A_TRIGGERED_CURRENT_LEVEL = 8'h08;
  localparam logic [7:0] A_VOLT_IMM  = 8'h0C;
  localparam logic [7:0] A_VOLT_TRIG = 8'h10;
  localparam logic [7:0] A_CTRL      = 8'h14;
  localparam logic [7:0] A_STAT      = 8'h18;
  localparam logic [7:0] A_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] A_IRQ_EN    = 8'h20;
  localparam logic [7:0] A_IRQ_CLR   = 8'h24;
  localparam logic [7:0] A_LIMIT     = 8'h28;
  localparam logic [7:0] A_SENSE     = 8'h2C;

  // ------------------------------------------------------------------
  // command codes written to A_CMD bits [3:0]
  // ------------------------------------------------------------------
  localparam logic [3:0] CMD_ABORT    = 4'h1;
  localparam logic [3:0] CMD_INIT     = 4'h2;
  localparam logic [3:0] CMD_TRIG     = 4'h3;
  localparam logic [3:0] CMD_PROT_CLR = 4'h4;
  localparam logic [3:0] CMD_WAIT     = 4'h5;
  localparam logic [3:0] CMD_DEV_CLR  = 4'h6;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CTRL_CONT  = 0;   // continuous initiation
  localparam int CTRL_OCP   = 1;   // overcurrent protect enable
  localparam int CTRL_OUT   = 2;   // output enable
  localparam int STAT_WTG   = 0;   // waiting for trigger
  localparam int STAT_OC    = 1;   // overcurrent flag
  localparam int STAT_OUT   = 2;   // output actually on
  localparam int STAT_HOLD  = 3;   // wait hold active
  localparam int STAT_TPEND = 4;   // triggered level programmed
  localparam int IRQ_W      = 3;
  localparam int IRQ_TRIG   = 0;   // trigger consumed
  localparam int IRQ_OC     = 1;   // overcurrent trip
  localparam int IRQ_ABORT  = 2;   // abort executed
  localparam int LIM_MAXSEL = 0;   // limit query: 1 = maximum
  localparam int LIM_TRSEL  = 1;   // limit query: 1 = triggered level
endpackage

// ---- logic/tls_apb_slave.sv ----
// apb slave front end: one-cycle access phase except for writes stalled by a wait hold, decodes strobes for the core
`timescale 1ns/1ps
module tls_apb_slave
  import tls_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // apb
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_hold,
  output logic             o_pready,
  // decoded access to core
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_addr,
  output logic [31:0]      o_wdata
);
  // ------------------------------------------------------------------
  // strobes
  // ------------------------------------------------------------------
  // while a wait hold stands, all writes stall in the access phase;
  // reads and the device-clear command still pass so the hold can end
  logic stall;
  assign stall = i_hold & i_pwrite & (i_paddr != A_CMD || i_pwdata[3:0] != CMD_DEV_CLR);
  assign o_pready = ~stall;
  assign o_wr     = i_psel & i_penable & i_pwrite & ~stall;
  // the read strobe marks the setup cycle, so the core registers read data
  // one edge early and it already stands when pready is sampled high
  assign o_rd     = i_psel & ~i_penable & ~i_pwrite;
  assign o_addr   = i_paddr;
  assign o_wdata  = i_pwdata;
endmodule

// ---- logic/tls_pend_tracker.sv ----
// pending-operation tracker: counts outstanding settle cycles after a level change
`timescale 1ns/1ps
module tls_pend_tracker #(
  parameter int SETTLE = 8
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  // control
  input  wire logic i_start,
  output logic      o_busy
);
  typedef struct packed {
    logic [7:0] cnt;
  } tls_pt_t;
  tls_pt_t s_r, s_nxt;

  // ------------------------------------------------------------------
  // countdown
  // ------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (i_start) begin
      s_nxt.cnt = 8'(SETTLE);
    end else if (s_r.cnt != 8'h00) begin
      s_nxt.cnt = s_r.cnt - 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_busy = (s_r.cnt != 8'h00);
endmodule

// ---- logic/tls_top.sv ----
// trigger level sequencer: levels, arming, abort, overcurrent protection over apb
//
// Operation
// - after a wait command, hold later writes until pending operations finish
// - only device clear ends a wait hold early; host sends it
// - abort cancels pending current and voltage levels, reloads them from immediate
// - abort clears the waiting-for-trigger flag
// - with continuous initiation, abort rearms and sets waiting-for-trigger again
// - abort action runs automatically after power-on reset
// - without programmed triggered level, immediate write loads both levels
// - once triggered level programmed, immediate writes leave it alone
// - trigger transfers the pending triggered level to the immediate level
// - protection on, output on and current above immediate level: output off, flag set
// - protection-clear command clears the overcurrent flag
// - protection enable takes 0 or 1 and reads back 0 or 1
// - while armed, trigger command or trigger input performs the trigger
// - while disarmed, triggers are ignored, nothing changes
// - continuous off: initiate arms for exactly one trigger
// - continuous on: always armed, initiate adds nothing
// - unprogrammed triggered level reads equal to immediate level
// - max/min limit queries return programmable limits, not programmed values
`timescale 1ns/1ps
module tls_top
  import tls_pkg::*;
#(
  parameter int SETTLE = 8
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  // apb
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic                  o_pready,
  output logic [31:0]           o_prdata,
  output logic                  o_pslverr,
  // group execute trigger from the bus pin, and sensed current
  input  wire logic             i_get,
  input  wire logic [LVL_W-1:0] i_sense_curr,
  // output stage
  output logic                  o_out_en,
  output logic [LVL_W-1:0]      o_curr_set,
  output logic [LVL_W-1:0]      o_volt_set,
  output logic                  o_irq
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [LVL_W-1:0] curr_imm;
    logic [LVL_W-1:0] triggered_current_level;
    logic [LVL_W-1:0] volt_imm;
    logic [LVL_W-1:0] volt_trig;
    logic             ctrig_set;
    logic             vtrig_set;
    logic             cont;
    logic             ocp_en;
    logic             out_req;
    logic             armed;
    logic             oc;
    logic             hold;
    logic             boot;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic [31:0]      rdata;
    logic             irq;
    logic             out_en;
    logic [2:0]       get_sync;
    logic             get_prev;
    logic [1:0]       lim_sel;
  } tls_st_t;
  tls_st_t s_r, s_nxt;

  logic             wr;
  logic             rd;
  logic [7:0]       addr;
  logic [31:0]      wdata;
  logic             busy;
  logic             lvl_chg;
  logic             sense_over;
  logic [31:0]      lim_word;

  // ------------------------------------------------------------------
  // bus front end and pending-operation tracker
  // ------------------------------------------------------------------
  tls_apb_slave u_apb (
    .i_mclk    (i_mclk),
    .i_rstn    (i_rstn),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .i_pwdata  (i_pwdata),
    .i_hold    (s_r.hold),
    .o_pready  (o_pready),
    .o_wr      (wr),
    .o_rd      (rd),
    .o_addr    (addr),
    .o_wdata   (wdata)
  );

  tls_pend_tracker #(.SETTLE(SETTLE)) u_pend (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_start (lvl_chg),
    .o_busy  (busy)
  );

  // sensed current is an analog-side sample on the same clock
  assign sense_over = i_sense_curr > s_r.curr_imm;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic cmd_wr;
    logic [3:0] cmd;
    logic trig;
    logic do_abort;
    logic get_edge;
    logic [IRQ_W-1:0] ev;
    cmd_wr   = 1'b0;
    cmd      = 4'h0;
    trig     = 1'b0;
    do_abort = 1'b0;
    get_edge = 1'b0;
    ev       = '0;
    lvl_chg  = 1'b0;
    s_nxt    = s_r;

    // three-stage sync on the trigger pin; edge needs stages two and three
    s_nxt.get_sync = {s_r.get_sync[1:0], i_get};
    if (s_r.get_sync[2] == s_r.get_sync[1]) begin
      s_nxt.get_prev = s_r.get_sync[2];
      get_edge = s_r.get_sync[2] & ~s_r.get_prev;
    end

    cmd_wr = wr && addr == A_CMD;
    cmd    = wdata[3:0];
    do_abort = s_r.boot | (cmd_wr && cmd == CMD_ABORT);
    s_nxt.boot = 1'b0;

    // wait hold ends when nothing is pending or on device clear
    if (s_r.hold && !busy) begin
      s_nxt.hold = 1'b0;
    end
    if (cmd_wr && cmd == CMD_DEV_CLR) begin
      s_nxt.hold = 1'b0;
    end
    if (cmd_wr && cmd == CMD_WAIT) begin
      s_nxt.hold = 1'b1;
    end

    // register writes
    if (wr) begin
      unique case (addr)
        A_CURR_IMM: begin
          s_nxt.curr_imm = wdata[LVL_W-1:0];
          lvl_chg = 1'b1;
          if (!s_r.ctrig_set) begin
            s_nxt.triggered_current_level = wdata[LVL_W-1:0];
          end // else pending level kept
        end
        A_TRIGGERED_CURRENT_LEVEL: begin
          s_nxt.triggered_current_level = wdata[LVL_W-1:0];
          s_nxt.ctrig_set = 1'b1;
        end
        A_VOLT_IMM: begin
          s_nxt.volt_imm = wdata[LVL_W-1:0];
          lvl_chg = 1'b1;
          if (!s_r.vtrig_set) begin
            s_nxt.volt_trig = wdata[LVL_W-1:0];
          end
        end
        A_VOLT_TRIG: begin
          s_nxt.volt_trig = wdata[LVL_W-1:0];
          s_nxt.vtrig_set = 1'b1;
        end
        A_CTRL: begin
          s_nxt.cont    = wdata[CTRL_CONT];
          s_nxt.ocp_en  = wdata[CTRL_OCP];
          s_nxt.out_req = wdata[CTRL_OUT];
        end
        A_IRQ_EN: begin
          s_nxt.irq_en = wdata[IRQ_W-1:0];
        end
        A_IRQ_CLR: begin
          s_nxt.irq_st = s_r.irq_st & ~wdata[IRQ_W-1:0];
        end
        A_LIMIT: begin
          s_nxt.lim_sel = {wdata[LIM_TRSEL], wdata[LIM_MAXSEL]};
        end
        default: begin
        end
      endcase
    end

    // arming
    if (cmd_wr && cmd == CMD_INIT) begin
      s_nxt.armed = 1'b1;
    end
    if (s_nxt.cont) begin
      s_nxt.armed = 1'b1;
    end

    // trigger: command or synchronised pin edge, only while armed
    trig = s_r.armed && ((cmd_wr && cmd == CMD_TRIG) || get_edge);
    if (trig && !do_abort) begin
      s_nxt.curr_imm  = s_r.triggered_current_level;
      s_nxt.volt_imm  = s_r.volt_trig;
      s_nxt.ctrig_set = 1'b0;
      s_nxt.vtrig_set = 1'b0;
      lvl_chg = 1'b1;
      ev[IRQ_TRIG] = 1'b1;
      if (!s_nxt.cont) begin
        s_nxt.armed = 1'b0;
      end
    end

    // abort: cancel pending levels, disarm, rearm if continuous
    if (do_abort) begin
      s_nxt.triggered_current_level = s_nxt.curr_imm;
      s_nxt.volt_trig = s_nxt.volt_imm;
      s_nxt.ctrig_set = 1'b0;
      s_nxt.vtrig_set = 1'b0;
      s_nxt.armed     = s_nxt.cont;
      ev[IRQ_ABORT]   = ~s_r.boot;
    end

    // overcurrent: clear command first so a new trip wins
    if (cmd_wr && cmd == CMD_PROT_CLR) begin
      s_nxt.oc = 1'b0;
    end
    if (s_r.ocp_en && sense_over && s_r.out_en) begin
      s_nxt.oc = 1'b1;
      ev[IRQ_OC] = ~s_r.oc;
    end
    s_nxt.out_en = s_nxt.out_req & ~s_nxt.oc;

    // sticky status: a new event wins over a clear in the same cycle
    s_nxt.irq_st = s_nxt.irq_st | ev;
    s_nxt.irq    = |(s_nxt.irq_st & s_nxt.irq_en);

    // read mux, taken in the setup cycle: prdata comes from a flip-flop
    // and still needs no wait state in the access phase
    if (rd) begin
      s_nxt.rdata = 32'h0000_0000;
      unique case (addr)
        A_CURR_IMM:  s_nxt.rdata[LVL_W-1:0] = s_r.curr_imm;
        A_TRIGGERED_CURRENT_LEVEL: s_nxt.rdata[LVL_W-1:0] = s_r.triggered_current_level;
        A_VOLT_IMM:  s_nxt.rdata[LVL_W-1:0] = s_r.volt_imm;
        A_VOLT_TRIG: s_nxt.rdata[LVL_W-1:0] = s_r.volt_trig;
        A_CTRL: begin
          s_nxt.rdata[CTRL_CONT] = s_r.cont;
          s_nxt.rdata[CTRL_OCP]  = s_r.ocp_en;
          s_nxt.rdata[CTRL_OUT]  = s_r.out_req;
        end
        A_STAT: begin
          s_nxt.rdata[STAT_WTG]   = s_r.armed;
          s_nxt.rdata[STAT_OC]    = s_r.oc;
          s_nxt.rdata[STAT_OUT]   = s_r.out_en;
          s_nxt.rdata[STAT_HOLD]  = s_r.hold;
          s_nxt.rdata[STAT_TPEND] = s_r.ctrig_set;
        end
        A_IRQ_STAT:  s_nxt.rdata[IRQ_W-1:0] = s_r.irq_st;
        A_IRQ_EN:    s_nxt.rdata[IRQ_W-1:0] = s_r.irq_en;
        A_LIMIT:     s_nxt.rdata = lim_word;
        A_SENSE:     s_nxt.rdata[LVL_W-1:0] = i_sense_curr;
        default:     s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // state register; boot flag forces one abort after reset release
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r           <= '0;
      s_r.curr_imm  <= CURR_RST;
      s_r.triggered_current_level <= CURR_RST;
      s_r.volt_imm  <= VOLT_RST;
      s_r.volt_trig <= VOLT_RST;
      s_r.boot      <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // limit query: select field chooses max/min and immediate/triggered;
  // limits are constants, never the programmed values
  always_comb begin
    lim_word = 32'h0000_0000;
    unique case (s_r.lim_sel)
      2'b00: lim_word[LVL_W-1:0] = CURR_MIN;
      2'b01: lim_word[LVL_W-1:0] = CURR_MAX;
      2'b10: lim_word[LVL_W-1:0] = TRIG_MIN;
      2'b11: lim_word[LVL_W-1:0] = TRIG_MAX;
    endcase
  end

  // outputs
  assign o_prdata  = s_r.rdata;
  assign o_pslverr = 1'b0;
  assign o_out_en  = s_r.out_en;
  assign o_curr_set = s_r.curr_imm;
  assign o_volt_set = s_r.volt_imm;
  assign o_irq     = s_r.irq;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  chk_abort_reload: assert property (wr && addr == A_CMD && wdata[3:0] == CMD_ABORT |=>
    s_r.triggered_current_level == s_r.curr_imm && !s_r.ctrig_set) else $error("abort left pending level");
  chk_abort_wtg: assert property (wr && addr == A_CMD && wdata[3:0] == CMD_ABORT && !s_r.cont
    && !(wr && addr == A_CTRL) |=> !s_r.armed) else $error("abort kept armed");
  chk_cont_armed: assert property (s_r.cont |-> s_r.armed) else $error("continuous not armed");
  chk_imm_both: assert property (wr && addr == A_CURR_IMM && !s_r.ctrig_set && !s_r.boot
    && !(wr && addr == A_CMD) |=> s_r.triggered_current_level == $past(wdata[LVL_W-1:0]))
    else $error("immediate write missed trigger level");
  chk_trig_move: assert property (s_r.armed && wr && addr == A_CMD && wdata[3:0] == CMD_TRIG
    && !s_r.boot |=> s_r.curr_imm == $past(s_r.triggered_current_level)) else $error("trigger did not move");
  chk_trig_ignored: assert property (!s_r.armed && !s_r.cont && !s_r.boot
    && !(wr && addr != A_CMD) && !(wr && wdata[3:0] == CMD_ABORT)
    |=> $stable(s_r.curr_imm)) else $error("disarmed trigger acted");
  chk_ocp_trip: assert property (s_r.ocp_en && sense_over && s_r.out_en |=> s_r.oc && !o_out_en)
    else $error("overcurrent not tripped");
  chk_single_shot: assert property (s_r.armed && !s_nxt.cont && wr && addr == A_CMD
    && wdata[3:0] == CMD_TRIG |=> !s_r.armed) else $error("single shot stayed armed");
  chk_hold_stall: assert property (s_r.hold && i_psel && i_pwrite && i_paddr == A_CURR_IMM
    |-> !o_pready) else $error("write passed a wait hold");

  cov_trigger: cover property (s_r.armed ##1 !s_r.armed);
  cov_trip:    cover property (!s_r.oc ##1 s_r.oc);
  cov_hold:    cover property (s_r.hold ##[1:20] !s_r.hold);
  cov_rearm:   cover property (s_r.cont && wr && addr == A_CMD && wdata[3:0] == CMD_ABORT);
endmodule

// ---- tb/tls_host_model.sv ----
// host controller model: apb master that issues commands and queries to the sequencer
`timescale 1ns/1ps
module tls_host_model (
  // clock
  input  wire logic        i_mclk,
  // apb answer
  input  wire logic        i_pready,
  input  wire logic [31:0] i_prdata,
  // apb request
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata
);
  int n_stall;

  // idle bus from time zero
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 8'h00;
    o_pwdata  = 32'h0000_0000;
    n_stall   = 0;
  end

  // one transfer; entered just after a rising edge, leaves one idle cycle behind
  // pready and read data are sampled at the rising edge that ends each access cycle
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    n_stall = 0;
    o_psel   <= 1'b1;
    o_pwrite <= wr;
    o_paddr  <= a;
    o_pwdata <= d;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    @(posedge i_mclk);
    while (i_pready !== 1'b1) begin
      n_stall++;
      @(posedge i_mclk);
    end
    q = i_prdata;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    @(posedge i_mclk);
  endtask
endmodule

// ---- tb/tls_top_test.sv ----
// self-checking bench of the trigger level sequencer driven through apb
`timescale 1ns/1ps
module tls_top_test
  import tls_pkg::*;
;
  logic              mclk;
  logic              rstn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic              pready;
  logic [31:0]       prdata;
  logic              pslverr;
  logic              get;
  logic [LVL_W-1:0]  sense;
  logic              out_en;
  logic [LVL_W-1:0]  curr_set;
  logic [LVL_W-1:0]  volt_set;
  logic              irq;
  logic [31:0]       q;
  logic [15:0]       lim [4];
  int                n_fail;
  int                n_tests;

  // long settle span keeps the hold visible but the run short
  tls_top #(.SETTLE(40)) i_dut (
    .i_mclk(mclk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_get(get), .i_sense_curr(sense), .o_out_en(out_en),
    .o_curr_set(curr_set), .o_volt_set(volt_set), .o_irq(irq)
  );

  tls_host_model i_host (
    .i_mclk(mclk), .i_pready(pready), .i_prdata(prdata), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  // read data stands in the access phase, so one transfer per read
  task automatic fetch(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    fetch(a);
    chk(q, e);
  endtask
  task automatic cmd(input logic [3:0] c);
    wr(A_CMD, {28'h0, c});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // the tests need well under 3000 cycles
  initial begin
    tick(20000);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail  = 0;
    n_tests = 0;
    rstn    = 1'b0;
    get     = 1'b0;
    sense   = 16'h0000;
    lim     = '{CURR_MIN, CURR_MAX, TRIG_MIN, TRIG_MAX};
    tick(16);
    rstn <= 1'b1;
    tick(2);
    // power-on state
    rd(A_CURR_IMM, {16'h0, CURR_RST});
    rd(A_TRIGGERED_CURRENT_LEVEL, {16'h0, CURR_RST});
    fetch(A_STAT);
    chkb(q[STAT_WTG], 1'b0);
    rd(A_CTRL, 32'h0);
    done("power_on");
    // immediate and triggered levels
    wr(A_CURR_IMM, 32'h0123);
    rd(A_TRIGGERED_CURRENT_LEVEL, 32'h0123);
    chk({16'h0, curr_set}, 32'h0123);
    wr(A_TRIGGERED_CURRENT_LEVEL, 32'h0456);
    wr(A_CURR_IMM, 32'h0200);
    rd(A_TRIGGERED_CURRENT_LEVEL, 32'h0456);
    done("levels");
    // arming and triggering
    cmd(CMD_TRIG);
    chk({16'h0, curr_set}, 32'h0200);
    cmd(CMD_INIT);
    fetch(A_STAT);
    chkb(q[STAT_WTG], 1'b1);
    cmd(CMD_TRIG);
    tick(2);
    chk({16'h0, curr_set}, 32'h0456);
    fetch(A_STAT);
    chkb(q[STAT_WTG], 1'b0);
    wr(A_TRIGGERED_CURRENT_LEVEL, 32'h0777);
    cmd(CMD_TRIG);
    tick(2);
    chk({16'h0, curr_set}, 32'h0456);
    cmd(CMD_INIT);
    get <= 1'b1;
    tick(3);
    get <= 1'b0;
    tick(8);
    chk({16'h0, curr_set}, 32'h0777);
    done("trigger");
    // abort drops pending levels
    wr(A_VOLT_IMM, 32'h0055);
    wr(A_VOLT_TRIG, 32'h0066);
    wr(A_TRIGGERED_CURRENT_LEVEL, 32'h0888);
    cmd(CMD_INIT);
    cmd(CMD_ABORT);
    rd(A_TRIGGERED_CURRENT_LEVEL, 32'h0777);
    rd(A_VOLT_TRIG, 32'h0055);
    fetch(A_STAT);
    chkb(q[STAT_WTG], 1'b0);
    done("abort");
    // continuous initiation
    wr(A_CTRL, 32'h1);
    cmd(CMD_ABORT);
    fetch(A_STAT);
    chkb(q[STAT_WTG], 1'b1);
    wr(A_TRIGGERED_CURRENT_LEVEL, 32'h0333);
    cmd(CMD_TRIG);
    cmd(CMD_INIT);
    fetch(A_STAT);
    chkb(q[STAT_WTG], 1'b1);
    chk({16'h0, curr_set}, 32'h0333);
    wr(A_TRIGGERED_CURRENT_LEVEL, 32'h0344);
    wr(A_VOLT_TRIG, 32'h0066);
    cmd(CMD_TRIG);
    tick(2);
    chk({16'h0, curr_set}, 32'h0344);
    chk({16'h0, volt_set}, 32'h0066);
    done("continuous");
    // overcurrent protection and its interrupt
    wr(A_CTRL, 32'h6);
    rd(A_CTRL, 32'h6);
    wr(A_IRQ_EN, 32'h2);
    sense <= 16'h0344;
    tick(4);
    chkb(out_en, 1'b1);
    sense <= 16'h0345;
    tick(4);
    chkb(out_en, 1'b0);
    fetch(A_STAT);
    chkb(q[STAT_OC], 1'b1);
    chkb(irq, 1'b1);
    wr(A_IRQ_EN, 32'h0);
    tick(2);
    chkb(irq, 1'b0);
    // cause removed before the clear
    sense <= 16'h0100;
    cmd(CMD_PROT_CLR);
    fetch(A_STAT);
    chkb(q[STAT_OC], 1'b0);
    chkb(out_en, 1'b1);
    wr(A_IRQ_EN, 32'h2);
    tick(2);
    chkb(irq, 1'b1);
    wr(A_IRQ_CLR, 32'h2);
    tick(2);
    chkb(irq, 1'b0);
    done("overcurrent");
    // limit queries
    for (int i = 0; i < 4; i++) begin
      wr(A_LIMIT, 32'(i));
      rd(A_LIMIT, {16'h0, lim[i]});
    end
    done("limits");
    // wait hold, released by settling and by device clear
    wr(A_CURR_IMM, 32'h0010);
    cmd(CMD_WAIT);
    fetch(A_STAT);
    chkb(q[STAT_HOLD], 1'b1);
    wr(A_CURR_IMM, 32'h0020);
    chkb(i_host.n_stall > 0, 1'b1);
    wr(A_CURR_IMM, 32'h0030);
    cmd(CMD_WAIT);
    cmd(CMD_DEV_CLR);
    chkb(i_host.n_stall == 0, 1'b1);
    fetch(A_STAT);
    chkb(q[STAT_HOLD], 1'b0);
    done("wait_hold");
    // unmapped address
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0);
    chkb(pslverr, 1'b0);
    done("unmapped");
    end_of_test();
  end
endmodule
